// file: logic/sdwpr_ctrl.sv
// memory controller end: write fifo, command sequencer and refresh timer
`default_nettype none
module sdwpr_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int FA = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [FA-1:0] wp;
    logic [FA-1:0] rp;
    logic [FA:0] cnt;
    logic rdy;
    logic vld;
  } sdwpr_fifo_t;
  sdwpr_fifo_t s_q, s_d;
  logic push;
  logic pop;

  // flags registered from the next count, so ports come from flops
  always_comb begin
    s_d = s_q;
    push = in_valid && s_q.rdy;
    pop = out_ready && s_q.vld;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) s_d.rp = s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + (FA + 1)'(push) - (FA + 1)'(pop);
    s_d.rdy = s_d.cnt != (FA + 1)'(D);
    s_d.vld = s_d.cnt != '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.rdy;
  assign out_valid = s_q.vld;
  assign out_data = s_q.mem[s_q.rp];
endmodule

module sdwpr_ctrl (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // access requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [sdwpr_pkg::AW-1:0] req_row,
  input wire logic [sdwpr_pkg::AW-1:0] req_col,
  output logic req_ack,
  // write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [sdwpr_pkg::DW-1:0] wr_data,
  // read data
  output logic rd_valid,
  output logic [sdwpr_pkg::DW-1:0] rd_data,
  // self refresh
  input wire logic sr_req,
  output logic sr_active,
  // memory pins
  sdwpr_if.ctrl mem
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_ACT = 9'h002, S_WR = 9'h004, S_RDL = 9'h008, S_PRE = 9'h010,
    S_RD = 9'h020, S_REF = 9'h040, S_SR = 9'h080, S_SRX = 9'h100
  } sdwpr_st_t;
  typedef struct packed {
    sdwpr_st_t st;
    logic [sdwpr_pkg::CW-1:0] cnt;
    logic [1:0] beat;
    logic [10:0] refi;
    logic ref_pend;
    logic we;
    logic [1:0] ba;
    logic [sdwpr_pkg::AW-1:0] col;
    logic cke;
    logic [3:0] pins;
    logic dqm;
    logic [1:0] mba;
    logic [sdwpr_pkg::AW-1:0] addr;
    logic [sdwpr_pkg::DW-1:0] dq_o;
    logic dq_oe_n;
    logic req_ack;
    logic rd_valid;
    logic [sdwpr_pkg::DW-1:0] rd_data;
    logic sr_active;
  } sdwpr_ctrl_t;
  sdwpr_ctrl_t s_q, s_d;
  logic tick;
  logic f_valid;
  logic f_ready;
  logic [sdwpr_pkg::DW-1:0] f_data;

  // drain only while a write burst is on the pins; the fill side keeps filling until the fifo is full
  assign f_ready = (s_q.st == S_ACT && s_q.cnt == '0 && s_q.we) || s_q.st == S_WR;

  sdwpr_fifo #(.W(sdwpr_pkg::DW), .D(sdwpr_pkg::FIFO_DEPTH)) u_wfifo (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // sequencer: closed page, one burst per request
  always_comb begin
    s_d = s_q;
    s_d.cke = 1'b1;
    s_d.pins = sdwpr_pkg::sdwpr_pins(sdwpr_pkg::CMD_NOP);
    s_d.dq_oe_n = 1'b1;
    s_d.dqm = 1'b0;
    s_d.req_ack = 1'b0;
    s_d.rd_valid = 1'b0;
    tick = 1'b0;
    if (s_q.st != S_SR && s_q.st != S_SRX) begin
      if (s_q.refi == '0) begin
        s_d.refi = sdwpr_pkg::REFI_CYC;
        tick = 1'b1;
      end else begin
        s_d.refi = s_q.refi - 1'b1;
      end
    end
    if (s_q.cnt != '0) s_d.cnt = s_q.cnt - 1'b1;
    case (s_q.st)
      S_IDLE: begin
        // banks all precharged here, at least tRP ago
        if (s_q.ref_pend) begin
          s_d.pins = sdwpr_pkg::sdwpr_pins(sdwpr_pkg::CMD_REF);
          s_d.ref_pend = 1'b0;
          s_d.cnt = sdwpr_pkg::RC_CYC - 1'b1;
          s_d.st = S_REF;
        end else if (sr_req) begin
          s_d.pins = sdwpr_pkg::sdwpr_pins(sdwpr_pkg::CMD_REF);
          s_d.cke = 1'b0;
          s_d.sr_active = 1'b1;
          s_d.st = S_SR;
        end else if (req_valid) begin
          s_d.pins = sdwpr_pkg::sdwpr_pins(sdwpr_pkg::CMD_ACT);
          s_d.mba = req_bank;
          s_d.addr = req_row;
          s_d.ba = req_bank;
          s_d.col = req_col;
          s_d.we = req_write;
          s_d.req_ack = 1'b1;
          s_d.cnt = sdwpr_pkg::RCD_CYC - 1'b1;
          s_d.st = S_ACT;
        end
      end
      S_ACT: begin
        if (s_q.cnt == '0) begin
          s_d.mba = s_q.ba;
          s_d.addr = s_q.col;
          s_d.addr[sdwpr_pkg::AP_BIT] = !s_q.we;
          if (s_q.we) begin
            s_d.pins = sdwpr_pkg::sdwpr_pins(sdwpr_pkg::CMD_WR);
            s_d.dq_oe_n = 1'b0;
            s_d.dq_o = f_data;
            s_d.dqm = !f_valid;
            s_d.beat = 2'h1;
            s_d.st = S_WR;
          end else begin
            s_d.pins = sdwpr_pkg::sdwpr_pins(sdwpr_pkg::CMD_RD);
            s_d.cnt = sdwpr_pkg::RD_WAIT;
            s_d.st = S_RD;
          end
        end
      end
      S_WR: begin
        // an empty fifo leaves a masked hole in the burst
        s_d.dq_oe_n = 1'b0;
        s_d.dq_o = f_data;
        s_d.dqm = !f_valid;
        s_d.beat = s_q.beat + 1'b1;
        if (s_q.beat == sdwpr_pkg::BEAT_LAST) begin
          s_d.cnt = sdwpr_pkg::RDL_CYC - 1'b1;
          s_d.st = S_RDL;
        end
      end
      S_RDL: begin
        if (s_q.cnt == '0) begin
          s_d.pins = sdwpr_pkg::sdwpr_pins(sdwpr_pkg::CMD_PRE);
          s_d.mba = s_q.ba;
          s_d.addr[sdwpr_pkg::AP_BIT] = 1'b0;
          s_d.cnt = sdwpr_pkg::RP_CYC - 1'b1;
          s_d.st = S_PRE;
        end
      end
      S_RD: begin
        if (s_q.cnt <= sdwpr_pkg::RD_HI && s_q.cnt >= sdwpr_pkg::RD_LO) begin
          s_d.rd_valid = 1'b1;
          s_d.rd_data = mem.dq;
        end
        if (s_q.cnt == '0) s_d.st = S_IDLE;
      end
      S_PRE, S_REF: begin
        if (s_q.cnt == '0) s_d.st = S_IDLE;
      end
      S_SR: begin
        s_d.cke = 1'b0;
        if (!sr_req) begin
          s_d.cnt = sdwpr_pkg::SRFC_CYC - 1'b1;
          s_d.st = S_SRX;
        end
      end
      S_SRX: begin
        if (s_q.cnt == '0) begin
          s_d.sr_active = 1'b0;
          s_d.ref_pend = 1'b1;
          s_d.st = S_IDLE;
        end
      end
      default: s_d.st = S_IDLE;
    endcase
    // timer set wins over the clear taken above
    if (tick) s_d.ref_pend = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.cke <= 1'b1;
      s_q.pins <= 4'hF;
      s_q.dq_oe_n <= 1'b1;
      s_q.refi <= sdwpr_pkg::REFI_CYC;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign mem.cke = s_q.cke;
  assign mem.cs_n = s_q.pins[3];
  assign mem.ras_n = s_q.pins[2];
  assign mem.cas_n = s_q.pins[1];
  assign mem.we_n = s_q.pins[0];
  assign mem.dqm = s_q.dqm;
  assign mem.ba = s_q.mba;
  assign mem.addr = s_q.addr;
  assign mem.dq_c_o = s_q.dq_o;
  assign mem.dq_c_oe_n = s_q.dq_oe_n;
  assign req_ack = s_q.req_ack;
  assign rd_valid = s_q.rd_valid;
  assign rd_data = s_q.rd_data;
  assign sr_active = s_q.sr_active;
endmodule
`default_nettype wire

// file: logic/sdwpr_device.sv
// sdram die end: command decode, bank timers, bursts, refresh and self refresh
//
// Contract
// - write starts on cs cas we low
// - first write word taken with command
// - controller masks extra data, precharges after recovery
// - controller uses two clock write recovery
// - precharge all needs select bit, ras met
// - single bank precharge after its ras time
// - refresh, mode write need all banks idle
// - select bit on column command auto precharges
// - controller refreshes every 15.6 us; timer period is 1951 cycles, 15.608 us at 125 MHz
// - refresh needs idle banks, prior clock enable
// - only nops during refresh row cycle
// - banks precharged tRP before refresh
// - refresh cycle time before activate or refresh
// - self refresh entered with clock enable low
// - self refresh ignores all but clock enable
// - exit: clock, enable high, nops for exit
// - burst refresh around self refresh recommended
// - mask hides reads two later, writes now
// - column command may follow one clock later
// - one more read word after interrupt
// - burst stop ends any burst, drops word
// - no interrupt of auto precharge burst
// - nop or deselect continues running work
`default_nettype none
module sdwpr_device (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // memory pins
  sdwpr_if.dev mem,
  // status
  output logic all_idle,
  output logic in_self_refresh,
  output logic [sdwpr_pkg::RW-1:0] refresh_row
);
  typedef struct packed {
    logic [sdwpr_pkg::BANKS-1:0] act;
    logic [sdwpr_pkg::BANKS-1:0] ap;
    logic [sdwpr_pkg::BANKS-1:0][sdwpr_pkg::CW-1:0] ras_cnt;
    logic [sdwpr_pkg::BANKS-1:0][sdwpr_pkg::CW-1:0] rp_cnt;
    logic wr;
    logic rd;
    logic [1:0] beat;
    logic [1:0] bank;
    logic [1:0] col;
    logic rd_v;
    logic [3:0] rd_idx;
    logic dqm_q;
    logic [sdwpr_pkg::MEM_WORDS-1:0][sdwpr_pkg::DW-1:0] mem;
    logic [sdwpr_pkg::RW-1:0] row;
    logic [sdwpr_pkg::CW-1:0] busy;
    logic [10:0] refi;
    logic sr;
    logic cke_q;
    logic [sdwpr_pkg::DW-1:0] dq_o;
    logic dq_oe_n;
    logic all_idle;
  } sdwpr_dev_t;

  sdwpr_dev_t s_q, s_d;
  sdwpr_pkg::sdwpr_cmd_t cmd;
  logic apb;
  logic live;
  logic intr;
  logic pre_ok;

  function automatic logic [3:0] idx(input logic [1:0] bk, input logic [1:0] cl);
    return {bk, cl};
  endfunction

  function automatic logic banks_idle(input logic [sdwpr_pkg::BANKS-1:0] a,
                                      input logic [sdwpr_pkg::BANKS-1:0][sdwpr_pkg::CW-1:0] r);
    logic ok;
    ok = 1'b1;
    for (int b = 0; b < sdwpr_pkg::BANKS; b++) begin
      if (a[b] || r[b] != '0) ok = 1'b0;
    end
    return ok;
  endfunction

  // wraps so 4096 commands visit every row once
  function automatic logic [sdwpr_pkg::RW-1:0] next_row(input logic [sdwpr_pkg::RW-1:0] r);
    return (r == sdwpr_pkg::ROW_LAST) ? '0 : r + 1'b1;
  endfunction

  // next-state of the whole die
  always_comb begin
    s_d = s_q;
    cmd = sdwpr_pkg::sdwpr_decode({mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n});
    apb = mem.addr[sdwpr_pkg::AP_BIT];
    live = 1'b0;
    intr = 1'b0;
    pre_ok = 1'b1;
    s_d.cke_q = mem.cke;
    if (s_q.sr) begin
      // only clock enable is looked at; rows refreshed by own timer
      s_d.dq_oe_n = 1'b1;
      if (mem.cke) begin
        s_d.sr = 1'b0;
        s_d.busy = sdwpr_pkg::SRFC_CYC;
        s_d.refi = sdwpr_pkg::REFI_CYC;
      end else if (s_q.refi == '0) begin
        s_d.refi = sdwpr_pkg::REFI_CYC;
        s_d.row = next_row(s_q.row);
      end else begin
        s_d.refi = s_q.refi - 1'b1;
      end
    end else if (s_q.cke_q) begin
      live = (s_q.busy == '0);
      if (s_q.busy != '0) s_d.busy = s_q.busy - 1'b1;
      // bank timers run whatever the command
      for (int b = 0; b < sdwpr_pkg::BANKS; b++) begin
        if (s_q.ras_cnt[b] != '0) s_d.ras_cnt[b] = s_q.ras_cnt[b] - 1'b1;
        if (s_q.rp_cnt[b] != '0) s_d.rp_cnt[b] = s_q.rp_cnt[b] - 1'b1;
        if (s_q.act[b] && s_q.ras_cnt[b] != '0) pre_ok = 1'b0;
      end
      // a new column command, stop, same-bank precharge or precharge all cuts the burst
      intr = live && (cmd == sdwpr_pkg::CMD_RD || cmd == sdwpr_pkg::CMD_WR ||
             cmd == sdwpr_pkg::CMD_STOP ||
             (cmd == sdwpr_pkg::CMD_PRE && (apb || mem.ba == s_q.bank)));
      s_d.rd_v = 1'b0;
      if (!intr && (s_q.wr || s_q.rd)) begin
        if (s_q.wr && !mem.dqm) begin
          s_d.mem[idx(s_q.bank, s_q.col + s_q.beat)] = mem.dq;
        end
        s_d.rd_v = s_q.rd;
        s_d.rd_idx = idx(s_q.bank, s_q.col + s_q.beat);
        s_d.beat = s_q.beat + 1'b1;
        if (s_q.beat == sdwpr_pkg::BEAT_LAST) begin
          s_d.wr = 1'b0;
          s_d.rd = 1'b0;
        end
      end
      // word at the stop edge is dropped; words already issued still leave
      if (intr) begin
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
      end
      if (live) begin
        case (cmd)
          sdwpr_pkg::CMD_ACT: begin
            if (!s_q.act[mem.ba] && s_q.rp_cnt[mem.ba] == '0) begin
              s_d.act[mem.ba] = 1'b1;
              s_d.ras_cnt[mem.ba] = sdwpr_pkg::RAS_CYC;
            end
          end
          sdwpr_pkg::CMD_WR: begin
            if (s_q.act[mem.ba]) begin
              s_d.wr = 1'b1;
              s_d.bank = mem.ba;
              s_d.col = mem.addr[1:0];
              s_d.beat = 2'h1;
              s_d.ap[mem.ba] = apb;
              if (!mem.dqm) s_d.mem[idx(mem.ba, mem.addr[1:0])] = mem.dq;
            end
          end
          sdwpr_pkg::CMD_RD: begin
            if (s_q.act[mem.ba]) begin
              s_d.rd = 1'b1;
              s_d.bank = mem.ba;
              s_d.col = mem.addr[1:0];
              s_d.beat = 2'h1;
              s_d.ap[mem.ba] = apb;
              s_d.rd_v = 1'b1;
              s_d.rd_idx = idx(mem.ba, mem.addr[1:0]);
            end
          end
          sdwpr_pkg::CMD_PRE: begin
            for (int b = 0; b < sdwpr_pkg::BANKS; b++) begin
              // all banks only once every open bank met its active time
              if (s_q.act[b] && ((apb && pre_ok) ||
                  (!apb && mem.ba == 2'(b) && s_q.ras_cnt[b] == '0))) begin
                s_d.act[b] = 1'b0;
                s_d.ap[b] = 1'b0;
                s_d.rp_cnt[b] = sdwpr_pkg::RP_CYC;
              end
            end
          end
          sdwpr_pkg::CMD_REF: begin
            if (banks_idle(s_q.act, s_q.rp_cnt)) begin
              s_d.row = next_row(s_q.row);
              if (mem.cke) begin
                s_d.busy = sdwpr_pkg::RC_CYC;
              end else begin
                s_d.sr = 1'b1;
                s_d.refi = sdwpr_pkg::REFI_CYC;
              end
            end
          end
          sdwpr_pkg::CMD_MRS: begin
            if (banks_idle(s_q.act, s_q.rp_cnt)) s_d.busy = sdwpr_pkg::MRS_CYC;
          end
          default: begin
          end
        endcase
      end
      // internal precharge once the burst left the bank and ras is met
      for (int b = 0; b < sdwpr_pkg::BANKS; b++) begin
        if (s_d.ap[b] && s_d.ras_cnt[b] == '0 &&
            !((s_d.wr || s_d.rd) && s_d.bank == 2'(b))) begin
          s_d.act[b] = 1'b0;
          s_d.ap[b] = 1'b0;
          s_d.rp_cnt[b] = sdwpr_pkg::AP_WAIT;
        end
      end
      // one stage of read pipe gives latency two; mask acts two edges on
      s_d.dqm_q = mem.dqm;
      s_d.dq_o = s_q.mem[s_q.rd_idx];
      s_d.dq_oe_n = !(s_q.rd_v && !s_q.dqm_q);
    end
    // low clock enable outside self refresh: everything else frozen
    s_d.all_idle = banks_idle(s_d.act, s_d.rp_cnt) && s_d.busy == '0 && !s_d.sr;
  end

  // single state register; ce freezes it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.dq_oe_n <= 1'b1;
      s_q.cke_q <= 1'b1;
      s_q.all_idle <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign mem.dq_d_o = s_q.dq_o;
  assign mem.dq_d_oe_n = s_q.dq_oe_n;
  assign all_idle = s_q.all_idle;
  assign in_self_refresh = s_q.sr;
  assign refresh_row = s_q.row;
endmodule
`default_nettype wire

// file: logic/sdwpr_if.sv
// pin bundle between memory controller and sdram die
`default_nettype none
interface sdwpr_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic dqm;
  logic [1:0] ba;
  logic [sdwpr_pkg::AW-1:0] addr;
  logic [sdwpr_pkg::DW-1:0] dq_c_o;
  logic dq_c_oe_n;
  logic [sdwpr_pkg::DW-1:0] dq_d_o;
  logic dq_d_oe_n;
  logic [sdwpr_pkg::DW-1:0] dq;
  // shared data wire; undriven bus reads as zero
  assign dq = !dq_d_oe_n ? dq_d_o : (!dq_c_oe_n ? dq_c_o : '0);
  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, dqm, ba, addr, dq_c_o, dq_c_oe_n,
    input dq
  );
  modport dev (
    input cke, cs_n, ras_n, cas_n, we_n, dqm, ba, addr, dq,
    output dq_d_o, dq_d_oe_n
  );
endinterface
`default_nettype wire

// file: logic/sdwpr_pkg.sv
// shared constants, command codes and pin helpers for both sdram ends
`default_nettype none
package sdwpr_pkg;
  // geometry
  localparam int CLK_MHZ = 125;
  localparam int BANKS = 4;
  localparam int AW = 12;
  localparam int DW = 16;
  localparam int BL = 4;
  localparam int CL = 2;
  localparam int AP_BIT = 10;
  localparam int MEM_WORDS = 16;
  localparam int CW = 5;
  localparam int RW = 12;
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [RW-1:0] ROW_LAST = 12'hFFF;
  // times in their own units
  localparam int T_RAS_NS = 42;
  localparam int T_RP_NS = 18;
  localparam int T_RCD_NS = 18;
  localparam int T_RC_NS = 105;
  localparam int T_SRFC_NS = 120;
  localparam int T_REFI_NS = 15600;
  localparam int T_RDL_CLK = 2;
  localparam int T_MRS_CLK = 2;
  // least times round up, longest times round down, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  function automatic int cyc_down(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [CW-1:0] RAS_CYC = CW'(cyc_up(T_RAS_NS));
  localparam logic [CW-1:0] RP_CYC = CW'(cyc_up(T_RP_NS));
  localparam logic [CW-1:0] RCD_CYC = CW'(cyc_up(T_RCD_NS));
  localparam logic [CW-1:0] RC_CYC = CW'(cyc_up(T_RC_NS));
  localparam logic [CW-1:0] SRFC_CYC = CW'(cyc_up(T_SRFC_NS));
  localparam logic [CW-1:0] RDL_CYC = CW'(T_RDL_CLK);
  localparam logic [CW-1:0] MRS_CYC = CW'(T_MRS_CLK);
  localparam logic [10:0] REFI_CYC = 11'(cyc_down(T_REFI_NS));
  localparam logic [CW-1:0] AP_WAIT = CW'(T_RDL_CLK + cyc_up(T_RP_NS));
  localparam logic [CW-1:0] RD_WAIT = CW'(CL + BL + cyc_up(T_RP_NS) + 1);
  localparam logic [CW-1:0] RD_HI = CW'(CL + BL + cyc_up(T_RP_NS) + 1 - CL);
  localparam logic [CW-1:0] RD_LO = CW'(CL + BL + cyc_up(T_RP_NS) + 1 - CL - BL + 1);
  // commands
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_STOP
  } sdwpr_cmd_t;
  // {cs_n, ras_n, cas_n, we_n} to command; deselect falls to nop
  function automatic sdwpr_cmd_t sdwpr_decode(input logic [3:0] p);
    case (p)
      4'h3: return CMD_ACT;
      4'h5: return CMD_RD;
      4'h4: return CMD_WR;
      4'h2: return CMD_PRE;
      4'h1: return CMD_REF;
      4'h0: return CMD_MRS;
      4'h6: return CMD_STOP;
      default: return CMD_NOP;
    endcase
  endfunction
  function automatic logic [3:0] sdwpr_pins(input sdwpr_cmd_t c);
    case (c)
      CMD_ACT: return 4'h3;
      CMD_RD: return 4'h5;
      CMD_WR: return 4'h4;
      CMD_PRE: return 4'h2;
      CMD_REF: return 4'h1;
      CMD_MRS: return 4'h0;
      CMD_STOP: return 4'h6;
      default: return 4'h7;
    endcase
  endfunction
endpackage
`default_nettype wire

// file: tb/sdwpr_monitor.sv
// checker on the pins between controller and die
`default_nettype none
module sdwpr_monitor (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic dqm,
  input wire logic [sdwpr_pkg::AW-1:0] addr,
  // data enables
  input wire logic dq_c_oe_n,
  input wire logic dq_d_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] p;
  logic nop, act, rd, wr, pre, rfs;
  // own pin decode, kept apart from the design's helper
  assign p = {cs_n, ras_n, cas_n, we_n};
  assign nop = cs_n | (p == 4'h7);
  assign act = (p == 4'h3);
  assign rd = (p == 4'h5);
  assign wr = (p == 4'h4);
  assign pre = (p == 4'h2);
  assign rfs = (p == 4'h1);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // read words two edges after the command, four in a row, then released
  read_burst_a: assert property (rd && cke |-> ##2 !dq_d_oe_n [*4] ##1 dq_d_oe_n)
    else $error("read burst timing wrong");
  // precharge waits the two clock recovery after the last word
  write_recovery_a: assert property (wr && !addr[sdwpr_pkg::AP_BIT] |=> !pre [*4] ##1 pre)
    else $error("write recovery wrong");
  // open bank kept open for its least active time
  ras_hold_a: assert property (act |=> !pre [*5])
    else $error("precharge too early");
  // first write word rides with the command
  write_data_a: assert property (wr && !dqm |-> !dq_c_oe_n && dq_d_oe_n)
    else $error("write word not driven");
  // only nops during the refresh row cycle
  refresh_quiet_a: assert property (rfs && cke |=> nop [*8] ##1 nop [*5])
    else $error("command inside refresh");
  // refresh never right behind a precharge
  refresh_idle_a: assert property (rfs |-> !$past(pre) && !$past(pre, 2))
    else $error("refresh before precharge time");
  // exit from self refresh followed by nops only
  exit_quiet_a: assert property ($rose(cke) |-> nop [*8] ##1 nop [*7])
    else $error("command inside exit time");
  // auto precharge read burst left alone
  ap_quiet_a: assert property (rd && addr[sdwpr_pkg::AP_BIT] |=> nop [*8])
    else $error("command during auto precharge");
endmodule
`default_nettype wire

// file: tb/tb_sdram_write_precharge_refresh.sv
// bench: controller and die back to back, table traffic, fifo fill, masking, self refresh
`default_nettype none
module tb_sdram_write_precharge_refresh;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [1:0] bank;
    logic [1:0] wcol;
    logic [1:0] rcol;
    logic [15:0] base;
    logic [15:0] first;
  } sdwpr_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_bank = 2'h0;
  logic [11:0] req_col = 12'h000;
  logic wr_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic sr_req = 1'b0;
  logic ce = 1'b1;
  logic req_ack, wr_ready, rd_valid, sr_active, all_idle, in_self_refresh;
  logic [15:0] rd_data;
  logic [11:0] refresh_row;
  logic [15:0] model [16];
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  sdwpr_if bus ();
  sdwpr_ctrl u_sdwpr_ctrl (.clock, .rst_n, .ce, .req_valid, .req_write, .req_bank,
    .req_row(12'h000), .req_col, .req_ack, .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data,
    .sr_req, .sr_active, .mem(bus.ctrl));
  sdwpr_device u_sdwpr_device (.clock, .rst_n, .ce, .mem(bus.dev), .all_idle,
    .in_self_refresh, .refresh_row);
  sdwpr_monitor u_sdwpr_monitor (.clock, .rst_n, .cke(bus.cke), .cs_n(bus.cs_n),
    .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .dqm(bus.dqm), .addr(bus.addr),
    .dq_c_oe_n(bus.dq_c_oe_n), .dq_d_oe_n(bus.dq_d_oe_n));
  always #4 clock = ~clock;
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one fifo word, held until the fifo takes it
  task automatic push(input logic [15:0] d);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_data <= d;
    do @(negedge clock); while (wr_ready !== 1'b1);
    @(posedge clock);
    wr_valid <= 1'b0;
  endtask
  // request held until acknowledged
  task automatic access(input logic w, input logic [1:0] b, input logic [1:0] c);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_bank <= b;
    req_col <= {10'h000, c};
    do @(negedge clock); while (req_ack !== 1'b1);
    @(posedge clock);
    req_valid <= 1'b0;
  endtask
  // expected storage: n words from column c, wrapping in the burst
  task automatic note(input logic [1:0] b, input logic [1:0] c, input logic [15:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      model[{b, c + 2'(k)}] = v + 16'(k);
    end
  endtask
  task automatic write_burst(input logic [1:0] b, input logic [1:0] c, input logic [15:0] v,
      input int n);
    for (int k = 0; k < n; k++) begin
      push(v + 16'(k));
    end
    access(1'b1, b, c);
    note(b, c, v, n);
  endtask
  task automatic read_check(input logic [1:0] b, input logic [1:0] c, output logic [15:0] w0);
    access(1'b0, b, c);
    for (int k = 0; k < 4; k++) begin
      do @(negedge clock); while (rd_valid !== 1'b1);
      if (k == 0) w0 = rd_data;
      check(rd_data, model[{b, c + 2'(k)}]);
      @(posedge clock);
    end
  endtask
  initial begin
    sdwpr_row_t rows [4];
    logic [11:0] r0;
    logic [15:0] w0;
    rows = '{'{2'h0, 2'h0, 2'h0, 16'h1000, 16'h1000}, '{2'h1, 2'h1, 2'h3, 16'h2100, 16'h2102},
      '{2'h2, 2'h3, 2'h2, 16'h3200, 16'h3203}, '{2'h3, 2'h2, 2'h0, 16'h4300, 16'h4302}};
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check(16'(wr_ready), 16'h0001);
    check(16'(all_idle), 16'h0001);
    // low clock enable freezes both ends: a self refresh request is not taken
    @(posedge clock);
    ce <= 1'b0;
    sr_req <= 1'b1;
    repeat (8) @(negedge clock);
    check(16'(sr_active), 16'h0000);
    check(16'(in_self_refresh), 16'h0000);
    @(posedge clock);
    ce <= 1'b1;
    sr_req <= 1'b0;
    foreach (rows[i]) begin
      write_burst(rows[i].bank, rows[i].wcol, rows[i].base, 4);
      read_check(rows[i].bank, rows[i].rcol, w0);
      check(w0, rows[i].first);
    end
    // fill the fifo until it refuses, then drain it with four bursts
    for (int i = 0; i < 16; i++) begin
      push(16'hA000 + 16'(i));
    end
    @(negedge clock);
    check(16'(wr_ready), 16'h0000);
    for (int j = 0; j < 4; j++) begin
      access(1'b1, 2'(j), 2'h0);
      note(2'(j), 2'h0, 16'hA000 + 16'(4 * j), 4);
    end
    @(negedge clock);
    check(16'(wr_ready), 16'h0001);
    for (int j = 0; j < 4; j++) begin
      read_check(2'(j), 2'h1, w0);
    end
    // two words only: the empty fifo masks the last two beats
    write_burst(2'h2, 2'h0, 16'hBB00, 2);
    read_check(2'h2, 2'h0, w0);
    @(negedge clock);
    r0 = refresh_row;
    @(posedge clock);
    sr_req <= 1'b1;
    do @(negedge clock); while (sr_active !== 1'b1);
    repeat (40) @(negedge clock);
    check(16'(in_self_refresh), 16'h0001);
    @(posedge clock);
    sr_req <= 1'b0;
    do @(negedge clock); while (sr_active !== 1'b0);
    repeat (40) @(negedge clock);
    check(16'(in_self_refresh), 16'h0000);
    check(16'(refresh_row == r0), 16'h0000);
    read_check(2'h1, 2'h2, w0);
    // settle first, so a refresh held back by the read cannot land twice in the window
    repeat (30) @(negedge clock);
    // timer fires at zero and reloads, so one period is its count plus one
    r0 = refresh_row;
    repeat (int'(sdwpr_pkg::REFI_CYC) + 1) @(negedge clock);
    r0 = refresh_row - r0;
    check(16'(r0), 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
